// ===== common/pkmc_pkg.sv
// constants and types shared by the palette key mode control block
package pkmc_pkg;

	// ------------------------------------------------------------
	// host register offsets
	// ------------------------------------------------------------
	localparam logic [15:0] ADR_MASK = 16'h03c6;
	localparam logic [15:0] ADR_RIDX = 16'h03c7;
	localparam logic [15:0] ADR_WIDX = 16'h03c8;
	localparam logic [15:0] ADR_DATA = 16'h03c9;

	// ------------------------------------------------------------
	// key sequence and special palette locations
	// ------------------------------------------------------------
	localparam logic [7:0]      KEY_INDEX = 8'hde;
	localparam logic [7:0]      MODE_LOC  = 8'hdf;
	localparam logic [3:0]      KEY_LAST  = 4'hb;
	localparam logic [7:0][7:0] KEY_BYTES = {8'h4e, 8'h55, 8'h53, 8'h44,
		8'h45, 8'h47, 8'h45, 8'h43};

	// ------------------------------------------------------------
	// mode byte codes
	// ------------------------------------------------------------
	localparam logic [7:0] MODE_B8     = 8'h05;
	localparam logic [7:0] MODE_B8_RC  = 8'h06;
	localparam logic [7:0] MODE_A4     = 8'h09;
	localparam logic [7:0] MODE_A4_RC  = 8'h0a;
	localparam logic [7:0] MODE_A4_RLD = 8'h0b;
	localparam logic [7:0] MODE_A8     = 8'h0d;
	localparam logic [7:0] MODE_A8_RC  = 8'h0e;
	localparam logic [7:0] MODE_A8_RLD = 8'h0f;

	// ------------------------------------------------------------
	// in-line reload opcodes and sequence lengths (last slot index)
	// ------------------------------------------------------------
	localparam logic [3:0] OP_A4       = 4'h7;
	localparam logic [7:0] OP_A8       = 8'hbf;
	localparam logic [2:0] RLD_LAST_A4 = 3'h7;
	localparam logic [2:0] RLD_LAST_A8 = 3'h4;

	// ------------------------------------------------------------
	// colour components and reset values
	// ------------------------------------------------------------
	localparam logic [1:0] COMP_RED  = 2'h0;
	localparam logic [1:0] COMP_BLUE = 2'h2;
	localparam logic [7:0] RST_MASK  = 8'hff;
	localparam logic [7:0] RST_MODE  = 8'h00;

	typedef enum logic [1:0] {
		ENC_COMPAT,
		ENC_BASIC8,
		ENC_ADV4,
		ENC_ADV8
	} pkmc_enc_e;

endpackage

// ===== hdl/pkmc_fifo.sv
// pixel fifo with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none

module pkmc_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	// filling side
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	// draining side
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
	localparam logic [AW:0]   CNT_FULL = (AW + 1)'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
		logic                    rdy;
		logic                    vld;
	} pkmc_fifo_s;

	pkmc_fifo_s s_q;
	pkmc_fifo_s s_d;
	logic       push;
	logic       pop;

	assign in_ready  = s_q.rdy;
	assign out_valid = s_q.vld;
	assign out_data  = s_q.mem[s_q.rp];

	always_comb begin
		s_d  = s_q;
		push = in_valid && s_q.rdy;
		pop  = out_ready && s_q.vld;
		if (push) begin
			s_d.mem[s_q.wp] = in_data;
			s_d.wp = (s_q.wp == PTR_LAST) ? '0 : s_q.wp + 1'b1;
		end
		if (pop) begin
			s_d.rp = (s_q.rp == PTR_LAST) ? '0 : s_q.rp + 1'b1;
		end
		if (push && !pop) begin
			s_d.cnt = s_q.cnt + 1'b1;
		end else if (pop && !push) begin
			s_d.cnt = s_q.cnt - 1'b1;
		end
		s_d.rdy = (s_d.cnt != CNT_FULL);
		s_d.vld = (s_d.cnt != '0);
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s_q     <= '0;
			s_q.rdy <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

endmodule

`default_nettype wire

// ===== hdl/pkmc_top.sv
// palette key detector, mode register and pixel sampling control
//
// How it works
// - compensation samples pixels every second clock
// - even line: skip first, then alternate
// - odd line: use first two, then even
// - split 4-bit reload spans eight nibble pixels
// - eight fixed key bytes, ninth is mode
// - key must arrive uninterrupted and in order
// - mode set only through a full key
// - wrong key or inhibit keeps compatibility
// - in enhanced mode, blue of entry 223 reads mode byte
// - mode byte selects encoding, replication, reload
// - data write to entry 223 clears mode
// - gamma on in enhanced, off in compatibility
// - enhanced mode hides upper mask bits
// - enhanced mask read: reserved bit, revision code
// - address advances after each colour triple
// - mode byte kept unshifted on write and read
// - value 7 or 191 is reload opcode
`timescale 1ns/10ps
`default_nettype none

module pkmc_top #(
	// revision code shown in the mask readback, value is arbitrary
	parameter logic [2:0] REV_CODE = 3'h2,
	parameter int         FIFO_W     = 8,
	parameter int         FIFO_DEPTH = 8
) (
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	// host register port
	input  wire logic [15:0]  host_addr,
	input  wire logic         host_wr_n,
	input  wire logic         host_rd_n,
	input  wire logic [7:0]   host_data_i,
	output logic [7:0]        host_data_o,
	output logic              host_data_oe,
	// mode inhibit pin
	input  wire logic         enhanced_mode_inhibit,
	// palette storage port
	output logic [7:0]        pal_addr,
	output logic [1:0]        pal_comp,
	output logic              pal_we,
	output logic [7:0]        pal_wdata,
	input  wire logic [7:0]   pal_rdata,
	// pixel input from the display controller
	input  wire logic [7:0]   pixel_in,
	input  wire logic         blank_n,
	output logic              pix_in_ready,
	// sampled pixel stream
	output logic [7:0]        pix_out,
	output logic              pix_out_valid,
	output logic              pix_out_rld,
	input  wire logic         pix_out_ready,
	// decoded mode
	output logic              edge_smoothing_mode,
	output logic [1:0]        enc_mode,
	output logic              inline_palette_reload,
	output logic              repl_comp,
	output logic              gamma_en,
	output logic [7:0]        pixel_mask,
	// in-line palette reload request
	output logic              rld_we,
	output logic [7:0]        rld_addr,
	output logic [23:0]       rld_rgb
);

	typedef struct packed {
		logic [2:0]          wrn;
		logic [2:0]          rdn;
		logic [15:0]         addr1;
		logic [15:0]         addr2;
		logic [7:0]          din1;
		logic [7:0]          din2;
		logic [1:0]          inh;
		logic [3:0]          step;
		logic                enh;
		logic [7:0]          mode;
		logic [7:0]          mask;
		logic [7:0]          radr;
		logic [7:0]          wadr;
		logic [1:0]          rcomp;
		logic [1:0]          wcomp;
		logic [7:0]          rdata;
		logic                oe;
		logic                pal_we;
		logic [7:0]          pal_addr;
		logic [1:0]          pal_comp;
		logic [7:0]          pal_wdata;
		pkmc_pkg::pkmc_enc_e enc;
		logic                rc;
		logic                reload;
		logic                blank_prev;
		logic                par;
		logic                ph;
		logic [7:0]          out_pix;
		logic                out_vld;
		logic                out_rld;
		logic [2:0]          rld_cnt;
		logic [23:0]         rld_buf;
		logic                rld_we;
		logic [7:0]          rld_addr;
		logic [23:0]         rld_rgb;
	} pkmc_top_s;

	pkmc_top_s   s_q;
	pkmc_top_s   s_d;
	logic        wr_ev;
	logic        rd_ev;
	logic [15:0] a;
	logic [7:0]  d;
	logic        mapped;
	logic        pal_acc;
	logic        idx_key;
	logic        key_hit;
	logic [2:0]  kidx;
	logic        first_px;
	logic        use_px;
	logic        cap_vld;
	logic        f_in_rdy;
	logic        f_out_vld;
	logic [7:0]  f_out_data;
	logic        f_out_rdy;
	logic        is_op;
	logic [2:0]  rld_last;
	logic        adv4;

	// ------------------------------------------------------------
	// pixel fifo
	// ------------------------------------------------------------
	pkmc_fifo #(
		.W     (FIFO_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.in_valid  (cap_vld),
		.in_data   (pixel_in),
		.in_ready  (f_in_rdy),
		.out_valid (f_out_vld),
		.out_data  (f_out_data),
		.out_ready (f_out_rdy)
	);

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign host_data_o           = s_q.rdata;
	assign host_data_oe          = s_q.oe;
	assign pal_addr              = s_q.pal_addr;
	assign pal_comp              = s_q.pal_comp;
	assign pal_we                = s_q.pal_we;
	assign pal_wdata             = s_q.pal_wdata;
	assign pix_in_ready          = f_in_rdy;
	assign pix_out               = s_q.out_pix;
	assign pix_out_valid         = s_q.out_vld;
	assign pix_out_rld           = s_q.out_rld;
	assign edge_smoothing_mode   = s_q.enh;
	assign enc_mode              = s_q.enc;
	assign inline_palette_reload = s_q.reload;
	assign repl_comp             = s_q.rc;
	assign gamma_en              = s_q.enh;
	assign pixel_mask            = s_q.mask;
	assign rld_we                = s_q.rld_we;
	assign rld_addr              = s_q.rld_addr;
	assign rld_rgb               = s_q.rld_rgb;

	always_comb begin
		s_d = s_q;

		// --------------------------------------------------------
		// host pin synchronisers and strobe edges
		// --------------------------------------------------------
		s_d.wrn   = {s_q.wrn[1:0], host_wr_n};
		s_d.rdn   = {s_q.rdn[1:0], host_rd_n};
		s_d.addr1 = host_addr;
		s_d.addr2 = s_q.addr1;
		s_d.din1  = host_data_i;
		s_d.din2  = s_q.din1;
		s_d.inh   = {s_q.inh[0], enhanced_mode_inhibit};
		wr_ev     = s_q.wrn[2] && !s_q.wrn[1];
		rd_ev     = s_q.rdn[2] && !s_q.rdn[1];
		a         = s_q.addr2;
		d         = s_q.din2;
		pal_acc   = (wr_ev || rd_ev) && (a == pkmc_pkg::ADR_RIDX
			|| a == pkmc_pkg::ADR_WIDX || a == pkmc_pkg::ADR_DATA);
		mapped    = pal_acc || a == pkmc_pkg::ADR_MASK;
		idx_key   = wr_ev && a == pkmc_pkg::ADR_RIDX
			&& d == pkmc_pkg::KEY_INDEX;
		kidx      = 3'(s_q.step - 4'h1 - {2'b00, s_q.step[3:2]});
		s_d.oe    = !s_q.rdn[1] && (a == pkmc_pkg::ADR_MASK
			|| a == pkmc_pkg::ADR_RIDX || a == pkmc_pkg::ADR_WIDX
			|| a == pkmc_pkg::ADR_DATA);

		// --------------------------------------------------------
		// palette port defaults
		// --------------------------------------------------------
		s_d.pal_we   = 1'b0;
		s_d.pal_addr = s_q.radr;
		s_d.pal_comp = s_q.rcomp;

		// --------------------------------------------------------
		// host writes
		// --------------------------------------------------------
		if (wr_ev) begin
			if (a == pkmc_pkg::ADR_MASK) begin
				s_d.mask = d;
			end else if (a == pkmc_pkg::ADR_RIDX) begin
				s_d.radr  = d;
				s_d.rcomp = pkmc_pkg::COMP_RED;
			end else if (a == pkmc_pkg::ADR_WIDX) begin
				s_d.wadr  = d;
				s_d.wcomp = pkmc_pkg::COMP_RED;
			end else if (a == pkmc_pkg::ADR_DATA) begin
				s_d.pal_we   = 1'b1;
				s_d.pal_addr = s_q.wadr;
				s_d.pal_comp = s_q.wcomp;
				s_d.pal_wdata = s_q.enh ? d : {d[5:0], 2'b00};
				if (s_q.wcomp == pkmc_pkg::COMP_BLUE) begin
					s_d.wcomp = pkmc_pkg::COMP_RED;
					s_d.wadr  = s_q.wadr + 8'h01;
				end else begin
					s_d.wcomp = s_q.wcomp + 2'h1;
				end
				if (s_q.wadr == pkmc_pkg::MODE_LOC) begin
					s_d.enh  = 1'b0;
					s_d.mode = pkmc_pkg::RST_MODE;
				end
			end
		end

		// --------------------------------------------------------
		// host reads
		// --------------------------------------------------------
		if (rd_ev) begin
			if (a == pkmc_pkg::ADR_MASK) begin
				s_d.rdata = s_q.enh ? {1'b0, REV_CODE, s_q.mask[3:0]}
					: s_q.mask;
			end else if (a == pkmc_pkg::ADR_DATA) begin
				if (s_q.enh && s_q.radr == pkmc_pkg::MODE_LOC
					&& s_q.rcomp == pkmc_pkg::COMP_BLUE) begin
					s_d.rdata = s_q.mode;
				end else if (s_q.enh) begin
					s_d.rdata = pal_rdata;
				end else begin
					s_d.rdata = {2'b00, pal_rdata[7:2]};
				end
				if (s_q.rcomp == pkmc_pkg::COMP_BLUE) begin
					s_d.rcomp = pkmc_pkg::COMP_RED;
					s_d.radr  = s_q.radr + 8'h01;
				end else begin
					s_d.rcomp = s_q.rcomp + 2'h1;
				end
			end else if (mapped) begin
				s_d.rdata = 8'h00;
			end
		end

		// --------------------------------------------------------
		// key detector
		// --------------------------------------------------------
		// expected access per step
		if (s_q.step[1:0] == 2'b00) begin
			key_hit = idx_key;
		end else begin
			key_hit = wr_ev && a == pkmc_pkg::ADR_DATA
				&& (s_q.step == pkmc_pkg::KEY_LAST
				|| d == pkmc_pkg::KEY_BYTES[kidx]);
		end
		if (s_q.inh[1]) begin
			s_d.enh  = 1'b0;
			s_d.mode = pkmc_pkg::RST_MODE;
		end
		if (pal_acc) begin
			if (key_hit && s_q.step == pkmc_pkg::KEY_LAST) begin
				s_d.step = 4'h0;
				if (!s_q.inh[1]) begin
					s_d.enh  = 1'b1;
					s_d.mode = d;
				end
			end else if (key_hit) begin
				s_d.step = s_q.step + 4'h1;
			end else begin
				s_d.step = idx_key ? 4'h1 : 4'h0;
			end
		end

		// --------------------------------------------------------
		// mode decode
		// --------------------------------------------------------
		s_d.enc    = pkmc_pkg::ENC_COMPAT;
		s_d.rc     = 1'b0;
		s_d.reload = 1'b0;
		if (s_d.enh) begin
			case (s_d.mode)
				pkmc_pkg::MODE_B8: begin
					s_d.enc = pkmc_pkg::ENC_BASIC8;
				end
				pkmc_pkg::MODE_B8_RC: begin
					s_d.enc = pkmc_pkg::ENC_BASIC8;
					s_d.rc  = 1'b1;
				end
				pkmc_pkg::MODE_A4: begin
					s_d.enc = pkmc_pkg::ENC_ADV4;
				end
				pkmc_pkg::MODE_A4_RC: begin
					s_d.enc = pkmc_pkg::ENC_ADV4;
					s_d.rc  = 1'b1;
				end
				pkmc_pkg::MODE_A4_RLD: begin
					s_d.enc    = pkmc_pkg::ENC_ADV4;
					s_d.reload = 1'b1;
				end
				pkmc_pkg::MODE_A8: begin
					s_d.enc = pkmc_pkg::ENC_ADV8;
				end
				pkmc_pkg::MODE_A8_RC: begin
					s_d.enc = pkmc_pkg::ENC_ADV8;
					s_d.rc  = 1'b1;
				end
				pkmc_pkg::MODE_A8_RLD: begin
					s_d.enc    = pkmc_pkg::ENC_ADV8;
					s_d.reload = 1'b1;
				end
				default: begin
					s_d.enc = pkmc_pkg::ENC_COMPAT;
				end
			endcase
		end

		// --------------------------------------------------------
		// replication compensation sampling
		// --------------------------------------------------------
		first_px       = blank_n && !s_q.blank_prev;
		s_d.blank_prev = blank_n;
		// line parity realigned at blank end
		s_d.par = first_px ? 1'b1 : ~s_q.par;
		use_px  = !s_q.rc || (first_px ? s_q.par : s_q.ph);
		s_d.ph  = first_px ? 1'b1 : ~s_q.ph;
		cap_vld = blank_n && use_px;

		// --------------------------------------------------------
		// output stage and in-line reload tracking
		// --------------------------------------------------------
		adv4      = s_q.enc == pkmc_pkg::ENC_ADV4;
		rld_last  = adv4 ? pkmc_pkg::RLD_LAST_A4 : pkmc_pkg::RLD_LAST_A8;
		is_op     = adv4 ? f_out_data[3:0] == pkmc_pkg::OP_A4
			: f_out_data == pkmc_pkg::OP_A8;
		f_out_rdy = !s_q.out_vld || pix_out_ready;
		s_d.rld_we = 1'b0;
		if (s_q.out_vld && pix_out_ready) begin
			s_d.out_vld = 1'b0;
		end
		if (!s_q.reload) begin
			s_d.rld_cnt = 3'h0;
		end
		if (f_out_vld && f_out_rdy) begin
			s_d.out_pix = f_out_data;
			s_d.out_vld = 1'b1;
			if (s_q.rld_cnt == 3'h0 || !s_q.reload) begin
				s_d.out_rld = s_q.reload && is_op;
				if (s_q.reload && is_op) begin
					s_d.rld_cnt = 3'h1;
				end
			end else if (s_q.rld_cnt == rld_last) begin
				s_d.out_rld  = 1'b1;
				s_d.rld_we   = 1'b1;
				s_d.rld_addr = adv4 ? {4'h0, f_out_data[3:0]} : f_out_data;
				s_d.rld_rgb  = s_q.rld_buf;
				s_d.rld_cnt  = 3'h0;
			end else begin
				s_d.out_rld = 1'b1;
				s_d.rld_buf = adv4 ? {s_q.rld_buf[19:0], f_out_data[3:0]}
					: {s_q.rld_buf[15:0], f_out_data};
				s_d.rld_cnt = s_q.rld_cnt + 3'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s_q      <= '0;
			s_q.wrn  <= 3'h7;
			s_q.rdn  <= 3'h7;
			s_q.mask <= pkmc_pkg::RST_MASK;
			s_q.mode <= pkmc_pkg::RST_MODE;
		end else begin
			s_q <= s_d;
		end
	end

endmodule

`default_nettype wire

// ===== tb/palette_key_mode_control_tb.sv
// self-checking testbench for the palette key mode control block
`timescale 1ns/10ps
`default_nettype none

module palette_key_mode_control_tb;
	localparam logic [2:0]  REV = 3'h2;
	localparam logic [15:0] MSK = 16'h03c6;
	localparam logic [15:0] RIX = 16'h03c7;
	localparam logic [15:0] WIX = 16'h03c8;
	localparam logic [15:0] DAT = 16'h03c9;
	localparam logic [7:0]  KEYV [8] = '{8'h43, 8'h45, 8'h47, 8'h45,
		8'h44, 8'h53, 8'h55, 8'h4e};
	localparam logic [7:0]  MODES [8] = '{8'h05, 8'h06, 8'h09, 8'h0a,
		8'h0b, 8'h0d, 8'h0e, 8'h0f};
	localparam logic [7:0]  PV [4] = '{8'h3f, 8'h01, 8'h22, 8'h15};
	localparam logic [7:0]  DP [8] = '{8'hf7, 8'h0a, 8'h05, 8'h03,
		8'h0c, 8'h09, 8'h06, 8'h04};
	localparam logic [7:0]  DQ [8] = '{8'hbf, 8'h12, 8'h34, 8'h56,
		8'h09, 8'h00, 8'h00, 8'h00};

	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic [15:0] host_addr = 16'h0000;
	logic        host_wr_n = 1'b1;
	logic        host_rd_n = 1'b1;
	logic [7:0]  host_data_i = 8'h00;
	logic        inhibit = 1'b0;
	logic        run = 1'b0;
	logic        ext = 1'b0;
	logic        ext_blank = 1'b0;
	logic [7:0]  ext_pix = 8'h00;
	logic [3:0]  blank_len = 4'h4;
	logic [7:0]  host_data_o, pal_addr, pal_wdata, pal_rdata, pixel_in;
	logic [7:0]  pix_out, pixel_mask, rld_addr, rdv;
	logic [1:0]  pal_comp, enc_mode;
	logic [23:0] rld_rgb;
	logic        host_data_oe, pal_we, blank_n, pix_out_valid, esm, rl, rc;
	logic        gamma_en, rld_we, rdoe, prdy, prl;
	logic [7:0]  got_q [$];
	int          fails = 0;
	int          checks_done = 0;
	int          nrl = 0;

	initial forever #10 clk_sys = ~clk_sys;

	pkmc_top #(.REV_CODE(REV)) uut (
		.clk_sys(clk_sys), .rst_n(rst_n), .host_addr(host_addr),
		.host_wr_n(host_wr_n), .host_rd_n(host_rd_n),
		.host_data_i(host_data_i), .host_data_o(host_data_o),
		.host_data_oe(host_data_oe), .enhanced_mode_inhibit(inhibit),
		.pal_addr(pal_addr), .pal_comp(pal_comp), .pal_we(pal_we),
		.pal_wdata(pal_wdata), .pal_rdata(pal_rdata), .pixel_in(pixel_in),
		.blank_n(blank_n), .pix_in_ready(prdy), .pix_out(pix_out),
		.pix_out_valid(pix_out_valid), .pix_out_rld(prl),
		.pix_out_ready(1'b1), .edge_smoothing_mode(esm),
		.enc_mode(enc_mode), .inline_palette_reload(rl), .repl_comp(rc),
		.gamma_en(gamma_en), .pixel_mask(pixel_mask), .rld_we(rld_we),
		.rld_addr(rld_addr), .rld_rgb(rld_rgb));

	pkmc_far_model far (
		.clk_sys(clk_sys), .run(run), .blank_len(blank_len), .ext(ext),
		.ext_blank(ext_blank), .ext_pix(ext_pix), .pixel_in(pixel_in),
		.blank_n(blank_n), .pal_addr(pal_addr), .pal_comp(pal_comp),
		.pal_we(pal_we), .pal_wdata(pal_wdata), .pal_rdata(pal_rdata));

	// sampled on the falling edge, where the outputs have settled
	always @(negedge clk_sys)
		if (pix_out_valid === 1'b1) begin
			got_q.push_back(pix_out);
			nrl += int'(prl === 1'b1);
		end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// one host cycle, strobes held well past the synchroniser
	task automatic acc(input logic [15:0] a, input logic w,
		input logic [7:0] d);
		@(negedge clk_sys);
		host_addr = a;
		host_data_i = d;
		repeat (3) @(negedge clk_sys);
		host_wr_n = !w;
		host_rd_n = w;
		repeat (5) @(negedge clk_sys);
		rdv = host_data_o;
		rdoe = host_data_oe;
		host_wr_n = 1'b1;
		host_rd_n = 1'b1;
		repeat (4) @(negedge clk_sys);
	endtask

	task automatic key(input logic [7:0] m, input int bad, input int ip);
		for (int i = 0; i < 8; i++) begin
			if (i % 3 == 0)
				acc(RIX, 1'b1, 8'hde);
			if (i == ip)
				acc(WIX, 1'b1, 8'h00);
			acc(DAT, 1'b1, KEYV[i] ^ {7'h00, i == bad});
		end
		acc(DAT, 1'b1, m);
	endtask

	// cleared while the pixel source is idle
	task automatic clr;
		acc(WIX, 1'b1, 8'hdf);
		acc(DAT, 1'b1, 8'h00);
	endtask

	task automatic lines(input logic [3:0] bl, input logic odd);
		logic [7:0] f [$];
		logic [7:0] e [$];
		got_q.delete();
		blank_len = bl;
		run = 1'b1;
		repeat (3 * (bl + 8)) @(negedge clk_sys);
		run = 1'b0;
		repeat (8) @(negedge clk_sys);
		foreach (got_q[i])
			if (got_q[i][7:4] != 4'h0)
				f.push_back(got_q[i]);
		for (int ln = 1; ln < 3; ln++) begin
			if (odd)
				e.push_back({ln[3:0], 4'h1});
			for (int p = 2; p < 9; p += 2)
				e.push_back({ln[3:0], p[3:0]});
		end
		chk(f.size(), e.size());
		foreach (e[i])
			chk(f[i], e[i]);
	endtask

	// one in-line reload burst, then wait for its pulse
	task automatic burst(input logic [7:0] m, input logic [7:0] px [8],
		input int n);
		key(m, 9, 9);
		ext = 1'b1;
		for (int i = 0; i < n; i++) begin
			@(negedge clk_sys);
			ext_blank = 1'b1;
			ext_pix = px[i];
		end
		@(negedge clk_sys);
		ext_blank = 1'b0;
		for (int i = 0; i < 30 && rld_we !== 1'b1; i++)
			@(negedge clk_sys);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (8) @(negedge clk_sys);
		rst_n = 1'b1;
		repeat (3) @(negedge clk_sys);
		chk({prdy, esm, gamma_en, enc_mode, pixel_mask}, 13'h10ff);
		acc(WIX, 1'b1, 8'h05);
		for (int i = 0; i < 4; i++)
			acc(DAT, 1'b1, PV[i]);
		acc(RIX, 1'b1, 8'h05);
		for (int i = 0; i < 4; i++) begin
			acc(DAT, 1'b0, 8'h00);
			chk(rdv, PV[i]);
		end
		chk(rdoe, 1'b1);
		acc(16'h03c5, 1'b0, 8'h00);
		chk(rdoe, 1'b0);
		key(8'h05, 4, 9);
		chk(esm, 1'b0);
		key(8'h05, 9, 5);
		chk(esm, 1'b0);
		acc(DAT, 1'b1, 8'h05);
		chk(esm, 1'b0);
		inhibit = 1'b1;
		key(8'h05, 9, 9);
		chk(esm, 1'b0);
		inhibit = 1'b0;
		foreach (MODES[i]) begin
			key(MODES[i], 9, 9);
			chk({esm, gamma_en, enc_mode, rc, rl}, {2'b11, MODES[i][3]
				? (MODES[i][2] ? 2'h3 : 2'h2) : 2'h1, MODES[i] == 8'h06
				|| MODES[i][1:0] == 2'h2,
				MODES[i][3] && MODES[i][1:0] == 2'h3});
			acc(RIX, 1'b1, 8'hdf);
			repeat (3) acc(DAT, 1'b0, 8'h00);
			chk(rdv, MODES[i]);
			acc(MSK, 1'b1, 8'hff);
			acc(MSK, 1'b0, 8'h00);
			chk(rdv, {1'b0, REV, 4'hf});
			clr;
			chk({esm, gamma_en}, 2'b00);
		end
		key(8'h05, 9, 9);
		acc(MSK, 1'b1, 8'h5a);
		chk(pixel_mask, 8'h5a);
		acc(MSK, 1'b0, 8'h00);
		chk(rdv, {1'b0, REV, 4'ha});
		clr;
		acc(MSK, 1'b0, 8'h00);
		chk(rdv, 8'h5a);
		key(8'h0e, 9, 9);
		lines(4'h4, 1'b0);
		lines(4'h5, 1'b1);
		burst(8'h0b, DP, 8);
		chk(rld_we, 1'b1);
		chk(rld_rgb, 24'ha53c96);
		chk(rld_addr, 8'h04);
		burst(8'h0f, DQ, 5);
		chk(rld_we, 1'b1);
		chk(rld_rgb, 24'h123456);
		chk(rld_addr, 8'h09);
		ext = 1'b0;
		clr;
		chk({esm, gamma_en}, 2'b00);
		chk(nrl, 13);
		print_verdict;
	end

	initial begin
		repeat (40000) @(posedge clk_sys);
		fails++;
		print_verdict;
	end
endmodule
`default_nettype wire

// ===== tb/pkmc_chk_sva.sv
// concurrent checks on the palette key mode control ports
`timescale 1ns/10ps
`default_nettype none

module pkmc_chk (
	// clock and reset
	input wire logic       clk_sys,
	input wire logic       rst_n,
	// inhibit pin
	input wire logic       enhanced_mode_inhibit,
	// palette storage port
	input wire logic [7:0] pal_addr,
	input wire logic       pal_we,
	input wire logic [7:0] pal_wdata,
	// decoded mode
	input wire logic       edge_smoothing_mode,
	input wire logic [1:0] enc_mode,
	input wire logic       inline_palette_reload,
	input wire logic       repl_comp,
	input wire logic       gamma_en,
	input wire logic       rld_we
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	// ------------------------------------------------------------
	// mode register
	// ------------------------------------------------------------
	a_gamma_tracks_mode: assert property (
		gamma_en == edge_smoothing_mode)
		else $error("gamma enable differs from mode state");
	a_inhibit_forces_compat: assert property (
		enhanced_mode_inhibit [*5] |-> !edge_smoothing_mode)
		else $error("enhanced mode active while inhibited");
	a_mode_needs_write: assert property (
		$rose(edge_smoothing_mode) |-> pal_we)
		else $error("mode set without a data port write");
	a_clear_on_entry: assert property (
		pal_we && pal_addr == pkmc_pkg::MODE_LOC
		&& !$rose(edge_smoothing_mode) |-> !edge_smoothing_mode)
		else $error("write to entry 223 left mode set");
	a_compat_shift_write: assert property (
		pal_we && !$past(edge_smoothing_mode) |-> pal_wdata[1:0] == 2'h0)
		else $error("compatibility write not left justified");
	a_compat_decode_zero: assert property (
		!edge_smoothing_mode |-> enc_mode == 2'h0 && !repl_comp
		&& !inline_palette_reload)
		else $error("mode attributes set in compatibility");
	a_repl_needs_enc: assert property (
		repl_comp |-> enc_mode != 2'h0)
		else $error("replication without encoding");

	// ------------------------------------------------------------
	// in-line reload
	// ------------------------------------------------------------
	a_reload_adv_only: assert property (
		inline_palette_reload |-> enc_mode[1] && !repl_comp)
		else $error("reload outside split encodings");
	a_reload_pulse_one: assert property (
		rld_we |=> !rld_we)
		else $error("reload pulse longer than one cycle");
	a_reload_gated_mode: assert property (
		rld_we |-> $past(inline_palette_reload))
		else $error("reload pulse with reload disabled");

	c_mode_cleared: cover property ($fell(edge_smoothing_mode));
	c_reload_done: cover property (rld_we);
	c_repl_active: cover property (repl_comp && gamma_en);
endmodule

bind pkmc_top pkmc_chk u_chk (
	.clk_sys,
	.rst_n,
	.enhanced_mode_inhibit,
	.pal_addr,
	.pal_we,
	.pal_wdata,
	.edge_smoothing_mode,
	.enc_mode,
	.inline_palette_reload,
	.repl_comp,
	.gamma_en,
	.rld_we
);
`default_nettype wire

// ===== tb/pkmc_far_model.sv
// display controller pixel source and palette storage model
`timescale 1ns/10ps
`default_nettype none

module pkmc_far_model (
	// clock
	input wire logic        clk_sys,
	// line generator control
	input wire logic        run,
	input wire logic [3:0]  blank_len,
	input wire logic        ext,
	input wire logic        ext_blank,
	input wire logic [7:0]  ext_pix,
	// pixel side
	output logic [7:0]      pixel_in,
	output logic            blank_n,
	// palette storage
	input wire logic [7:0]  pal_addr,
	input wire logic [1:0]  pal_comp,
	input wire logic        pal_we,
	input wire logic [7:0]  pal_wdata,
	output logic [7:0]      pal_rdata
);
	logic [4:0] cnt_q = 5'h00;
	logic [3:0] line_q = 4'h0;
	logic [7:0] junk_q = 8'h00;
	logic [7:0] mem [0:1023];
	logic       act;
	logic [4:0] pos;

	assign act = run && (cnt_q >= {1'b0, blank_len});
	assign pos = cnt_q - {1'b0, blank_len} + 5'h01;
	assign blank_n = ext ? ext_blank : act;
	// pixel carries line and position, junk during blanking
	assign pixel_in = ext ? ext_pix : (act ? {line_q, pos[3:0]} : junk_q);
	assign pal_rdata = mem[{pal_addr, pal_comp}];

	always_ff @(posedge clk_sys) begin
		junk_q <= junk_q + 8'h35;
		if (!run || cnt_q == {1'b0, blank_len} + 5'h07) begin
			cnt_q <= 5'h00;
			line_q <= run ? line_q + 4'h1 : 4'h0;
		end else begin
			cnt_q <= cnt_q + 5'h01;
		end
		if (pal_we)
			mem[{pal_addr, pal_comp}] <= pal_wdata;
	end
endmodule
`default_nettype wire
